// file: rtl/rcr_defines.svh
// register offsets, reset values, write masks and field positions of the
// receiver configuration bank; plain macros, included by bare name
`ifndef RCR_DEFINES_SVH
`define RCR_DEFINES_SVH

// byte offsets on the two-wire host port
`define RCR_ADDR_CTRL1 8'h00
`define RCR_ADDR_CTRL2 8'h01
`define RCR_ADDR_VSBC 8'h03
`define RCR_ADDR_GAIN 8'h04
`define RCR_ADDR_ILOW 8'h1b
`define RCR_ADDR_IMID 8'h1c

// reset values
`define RCR_RST_CTRL1 8'h20
`define RCR_RST_CTRL2 8'h11
`define RCR_RST_VSBC 8'h02
`define RCR_RST_GAIN 8'h07
`define RCR_RST_ILOW 8'hbc
`define RCR_RST_IMID 8'h64

// writable bits; the rest hold their reset level
`define RCR_WMASK_CTRL1 8'hff
`define RCR_WMASK_CTRL2 8'h3f
`define RCR_WMASK_VSBC 8'h10
`define RCR_WMASK_GAIN 8'h04

// field positions
`define RCR_CTRL1_DEMOD_HI 1
`define RCR_CTRL1_DEMOD_LO 0
`define RCR_CTRL2_SHIFT_BIT 5
`define RCR_CTRL2_COCH_HI 3
`define RCR_CTRL2_COCH_LO 2
`define RCR_CTRL2_ADJ_BIT 1
`define RCR_VSBC_NOAUTO_BIT 4
`define RCR_GAIN_INV_BIT 2

// host port slave address; the value is arbitrary
`define RCR_I2C_ADDR 7'h2a

`endif

// file: rtl/rcr_pkg.sv
// types shared by the receiver configuration bank
// assumes nothing beyond a SystemVerilog compiler
package rcr_pkg;

  typedef enum logic [1:0] {
    DEMOD_VSB8 = 2'b00,
    DEMOD_RSVD = 2'b01,
    DEMOD_QAM64 = 2'b10,
    DEMOD_QAM256 = 2'b11
  } rcr_demod_e;

  typedef enum logic [1:0] {
    COCH_AUTO = 2'b00,
    COCH_BYPASS = 2'b01,
    COCH_INSERT = 2'b10,
    COCH_RSVD = 2'b11
  } rcr_coch_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_SUB = 3'b010,
    ST_WR = 3'b011,
    ST_ACK = 3'b100,
    ST_RD = 3'b101,
    ST_RACK = 3'b110
  } rcr_i2c_e;

  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } rcr_wr_s;

  // settings in force in the receiver, loaded at soft reset
  typedef struct packed {
    logic [7:0] ctrl2;
    logic [7:0] gain;
    logic [7:0] imid;
    rcr_demod_e demod;
  } rcr_cfg_s;

endpackage

// file: rtl/rcr_pin_sync.sv
// three-stage synchroniser for pins from outside the clock domain
// a change is taken once stages two and three agree
module rcr_pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] pins_in,
  output logic [WIDTH-1:0] clean_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic take_q;
      // one process per bit owns its own flop; the port bit is a plain wire copy
      assign clean_out[i] = take_q;
      // bus lines idle high, so all stages reset high
      always_ff @(posedge mclk_in)
      begin
        if (reset_in)
        begin
          s1_q <= 1'b1;
          s2_q <= 1'b1;
          s3_q <= 1'b1;
          take_q <= 1'b1;
        end
        else
        begin
          s1_q <= pins_in[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q)
          begin
            take_q <= s3_q;
          end
        end
      end
    end
  endgenerate

endmodule

// file: rtl/rcr_config_regs.sv
// receiver configuration bank behind the two-wire host port
// host drives scl/sda; sda is open drain, the bench resolves the wire
`include "rcr_defines.svh"

module rcr_config_regs #(
  parameter logic [6:0] I2C_ADDR = `RCR_I2C_ADDR
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_drive_out,
  output logic sda_oe_out,
  input wire logic segment_error_excess_in,
  input wire logic gain_control_raw_in,
  input wire logic [7:0] vsb_interval_byte2_in,
  output logic [1:0] demod_type_select_out,
  output logic spectrum_shift_sel_out,
  output logic iq_swap_out,
  output logic [1:0] cochannel_filter_ctrl_out,
  output logic adjacent_filter_bypass_out,
  output logic auto_restart_disable_out,
  output logic gain_control_out,
  output logic [23:0] vsb_interval_count_out,
  output logic soft_reset_out,
  output logic restart_acq_out
);

  logic [1:0] pins_c;
  logic scl_c;
  logic sda_c;
  logic scl_p_q;
  logic sda_p_q;
  logic start_w;
  logic stop_w;
  logic scl_rise;
  logic scl_fall;
  rcr_pkg::rcr_i2c_e state_q;
  rcr_pkg::rcr_i2c_e after_q;
  logic [3:0] bitcnt_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  logic [7:0] tx_q;
  logic oe_q;
  logic nack_q;
  rcr_pkg::rcr_wr_s wr_q;
  logic [7:0] rd_byte;
  logic [7:0] ctrl1_q;
  logic [7:0] ctrl2_q;
  logic [7:0] vsbc_q;
  logic [7:0] gain_q;
  logic [7:0] ilow_q;
  logic [7:0] imid_q;
  rcr_pkg::rcr_cfg_s cfg_q;
  logic soft_req;
  logic qam_w;
  logic iq_swap_d;
  logic [1:0] coch_d;
  logic adj_d;
  logic restart_d;
  logic gain_d;
  logic [23:0] interval_d;
  logic past_ok_q;

  rcr_pin_sync #(
    .WIDTH(2)
  ) u_sync (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .pins_in({scl_in, sda_in}),
    .clean_out(pins_c)
  );

  assign scl_c = pins_c[1];
  assign sda_c = pins_c[0];
  assign start_w = scl_c && scl_p_q && sda_p_q && !sda_c;
  assign stop_w = scl_c && scl_p_q && !sda_p_q && sda_c;
  assign scl_rise = scl_c && !scl_p_q;
  assign scl_fall = !scl_c && scl_p_q;

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      scl_p_q <= scl_c;
      sda_p_q <= sda_c;
    end
  end

  // reads return the pending copy, so software sees what it wrote
  always_comb
  begin
    case (ptr_q)
      `RCR_ADDR_CTRL1: rd_byte = ctrl1_q;
      `RCR_ADDR_CTRL2: rd_byte = ctrl2_q;
      `RCR_ADDR_VSBC: rd_byte = vsbc_q;
      `RCR_ADDR_GAIN: rd_byte = gain_q;
      `RCR_ADDR_ILOW: rd_byte = ilow_q;
      `RCR_ADDR_IMID: rd_byte = imid_q;
      default: rd_byte = 8'h00;
    endcase
  end

  // byte engine: sample on scl rise, change sda only while scl is low
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      state_q <= rcr_pkg::ST_IDLE;
      after_q <= rcr_pkg::ST_IDLE;
      bitcnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      tx_q <= 8'h00;
      oe_q <= 1'b0;
      nack_q <= 1'b0;
      wr_q <= '0;
    end
    else
    begin
      wr_q.en <= 1'b0;
      if (stop_w)
      begin
        state_q <= rcr_pkg::ST_IDLE;
        oe_q <= 1'b0;
      end
      else if (start_w)
      begin
        state_q <= rcr_pkg::ST_ADDR;
        bitcnt_q <= 4'h0;
        oe_q <= 1'b0;
      end
      else
      begin
        case (state_q)
          rcr_pkg::ST_ADDR, rcr_pkg::ST_SUB, rcr_pkg::ST_WR:
          begin
            if (scl_rise)
            begin
              shift_q <= {shift_q[6:0], sda_c};
              bitcnt_q <= bitcnt_q + 4'h1;
            end
            else if (scl_fall && bitcnt_q == 4'h8)
            begin
              bitcnt_q <= 4'h0;
              state_q <= rcr_pkg::ST_ACK;
              oe_q <= 1'b1;
              if (state_q == rcr_pkg::ST_ADDR)
              begin
                after_q <= shift_q[0] ? rcr_pkg::ST_RD : rcr_pkg::ST_SUB;
                if (shift_q[7:1] != I2C_ADDR)
                begin
                  state_q <= rcr_pkg::ST_IDLE;
                  oe_q <= 1'b0;
                end
              end
              else if (state_q == rcr_pkg::ST_SUB)
              begin
                ptr_q <= shift_q;
                after_q <= rcr_pkg::ST_WR;
              end
              else
              begin
                wr_q.en <= 1'b1;
                wr_q.addr <= ptr_q;
                wr_q.data <= shift_q;
                ptr_q <= ptr_q + 8'h01;
                after_q <= rcr_pkg::ST_WR;
              end
            end
          end
          rcr_pkg::ST_ACK, rcr_pkg::ST_RACK:
          begin
            if (scl_rise && state_q == rcr_pkg::ST_RACK)
            begin
              nack_q <= sda_c;
            end
            else if (scl_fall)
            begin
              bitcnt_q <= 4'h0;
              if (state_q == rcr_pkg::ST_RACK && nack_q)
              begin
                state_q <= rcr_pkg::ST_IDLE;
                oe_q <= 1'b0;
              end
              else if (state_q == rcr_pkg::ST_RACK || after_q == rcr_pkg::ST_RD)
              begin
                tx_q <= rd_byte;
                ptr_q <= ptr_q + 8'h01;
                oe_q <= !rd_byte[7];
                state_q <= rcr_pkg::ST_RD;
              end
              else
              begin
                oe_q <= 1'b0;
                state_q <= after_q;
              end
            end
          end
          rcr_pkg::ST_RD:
          begin
            if (scl_rise)
            begin
              bitcnt_q <= bitcnt_q + 4'h1;
            end
            else if (scl_fall)
            begin
              if (bitcnt_q == 4'h8)
              begin
                oe_q <= 1'b0;
                state_q <= rcr_pkg::ST_RACK;
              end
              else
              begin
                tx_q <= {tx_q[6:0], 1'b0};
                oe_q <= !tx_q[6];
              end
            end
          end
          default: state_q <= rcr_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // pending copies; fixed bits keep their reset level
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      ctrl1_q <= `RCR_RST_CTRL1;
      ctrl2_q <= `RCR_RST_CTRL2;
      vsbc_q <= `RCR_RST_VSBC;
      gain_q <= `RCR_RST_GAIN;
      ilow_q <= `RCR_RST_ILOW;
      imid_q <= `RCR_RST_IMID;
    end
    else if (wr_q.en)
    begin
      case (wr_q.addr)
        `RCR_ADDR_CTRL1: ctrl1_q <= wr_q.data;
        `RCR_ADDR_CTRL2:
          ctrl2_q <= (wr_q.data & `RCR_WMASK_CTRL2) | (`RCR_RST_CTRL2 & ~`RCR_WMASK_CTRL2);
        `RCR_ADDR_VSBC:
          vsbc_q <= (wr_q.data & `RCR_WMASK_VSBC) | (`RCR_RST_VSBC & ~`RCR_WMASK_VSBC);
        `RCR_ADDR_GAIN:
          gain_q <= (wr_q.data & `RCR_WMASK_GAIN) | (`RCR_RST_GAIN & ~`RCR_WMASK_GAIN);
        `RCR_ADDR_ILOW: ilow_q <= wr_q.data;
        `RCR_ADDR_IMID: imid_q <= wr_q.data;
        default: ;
      endcase
    end
  end

  assign soft_req = wr_q.en && wr_q.addr == `RCR_ADDR_CTRL1;

  // staged settings move into force only on soft reset
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      cfg_q.ctrl2 <= `RCR_RST_CTRL2;
      cfg_q.gain <= `RCR_RST_GAIN;
      cfg_q.imid <= `RCR_RST_IMID;
      cfg_q.demod <= rcr_pkg::DEMOD_VSB8;
    end
    else if (soft_req)
    begin
      cfg_q.ctrl2 <= ctrl2_q;
      cfg_q.gain <= gain_q;
      cfg_q.imid <= imid_q;
      cfg_q.demod <= rcr_pkg::rcr_demod_e'(wr_q.data[`RCR_CTRL1_DEMOD_HI:`RCR_CTRL1_DEMOD_LO]);
    end
  end

  // reserved demod code 01 is run as VSB; only the top bit marks QAM
  assign qam_w = cfg_q.demod[1];
  assign iq_swap_d = qam_w && cfg_q.ctrl2[`RCR_CTRL2_SHIFT_BIT];
  assign coch_d = qam_w ? rcr_pkg::COCH_BYPASS :
                  cfg_q.ctrl2[`RCR_CTRL2_COCH_HI:`RCR_CTRL2_COCH_LO];
  assign adj_d = qam_w || cfg_q.ctrl2[`RCR_CTRL2_ADJ_BIT];
  // disable bit and low interval byte are not staged, they act at once
  assign restart_d = soft_req || (!qam_w && segment_error_excess_in &&
                     !vsbc_q[`RCR_VSBC_NOAUTO_BIT]);
  assign gain_d = gain_control_raw_in ^ cfg_q.gain[`RCR_GAIN_INV_BIT];
  assign interval_d = {vsb_interval_byte2_in, cfg_q.imid, ilow_q};

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      sda_drive_out <= 1'b0;
      sda_oe_out <= 1'b0;
      demod_type_select_out <= rcr_pkg::DEMOD_VSB8;
      spectrum_shift_sel_out <= 1'b0;
      iq_swap_out <= 1'b0;
      cochannel_filter_ctrl_out <= rcr_pkg::COCH_AUTO;
      adjacent_filter_bypass_out <= 1'b0;
      auto_restart_disable_out <= 1'b0;
      gain_control_out <= 1'b0;
      vsb_interval_count_out <= 24'h00_0000;
      soft_reset_out <= 1'b0;
      restart_acq_out <= 1'b0;
      past_ok_q <= 1'b0;
    end
    else
    begin
      sda_drive_out <= 1'b0;
      sda_oe_out <= oe_q;
      demod_type_select_out <= cfg_q.demod;
      spectrum_shift_sel_out <= cfg_q.ctrl2[`RCR_CTRL2_SHIFT_BIT];
      iq_swap_out <= iq_swap_d;
      cochannel_filter_ctrl_out <= coch_d;
      adjacent_filter_bypass_out <= adj_d;
      auto_restart_disable_out <= vsbc_q[`RCR_VSBC_NOAUTO_BIT];
      gain_control_out <= gain_d;
      vsb_interval_count_out <= interval_d;
      soft_reset_out <= soft_req;
      restart_acq_out <= restart_d;
      past_ok_q <= 1'b1;
    end
  end

  property p_pending_hold;
    @(posedge mclk_in) disable iff (reset_in)
    (wr_q.en && wr_q.addr == `RCR_ADDR_CTRL2) |=> $stable(cfg_q.ctrl2) && $stable(cfg_q.gain);
  endproperty
  a_pending_hold: assert property (p_pending_hold) else $error("staged value applied early");

  property p_soft_apply;
    @(posedge mclk_in) disable iff (reset_in)
    soft_req |=> cfg_q.ctrl2 == $past(ctrl2_q) && cfg_q.imid == $past(imid_q) && soft_reset_out;
  endproperty
  a_soft_apply: assert property (p_soft_apply) else $error("soft reset did not apply");

  property p_shift;
    @(posedge mclk_in) disable iff (reset_in)
    past_ok_q |-> spectrum_shift_sel_out == $past(cfg_q.ctrl2[`RCR_CTRL2_SHIFT_BIT]);
  endproperty
  a_shift: assert property (p_shift) else $error("spectrum shift mismatch");

  property p_iq_swap;
    @(posedge mclk_in) disable iff (reset_in)
    past_ok_q && iq_swap_out |-> $past(qam_w) && spectrum_shift_sel_out;
  endproperty
  a_iq_swap: assert property (p_iq_swap) else $error("swap outside QAM");

  property p_coch;
    @(posedge mclk_in) disable iff (reset_in)
    past_ok_q && !$past(qam_w) |-> cochannel_filter_ctrl_out ==
      $past(cfg_q.ctrl2[`RCR_CTRL2_COCH_HI:`RCR_CTRL2_COCH_LO]);
  endproperty
  a_coch: assert property (p_coch) else $error("co-channel field not passed in VSB");

  property p_qam_bypass;
    @(posedge mclk_in) disable iff (reset_in)
    qam_w [*2] |-> cochannel_filter_ctrl_out == rcr_pkg::COCH_BYPASS && adjacent_filter_bypass_out;
  endproperty
  a_qam_bypass: assert property (p_qam_bypass) else $error("filter not bypassed in QAM");

  property p_adj;
    @(posedge mclk_in) disable iff (reset_in)
    past_ok_q && !$past(qam_w) |-> adjacent_filter_bypass_out == $past(cfg_q.ctrl2[1]);
  endproperty
  a_adj: assert property (p_adj) else $error("adjacent bypass mismatch in VSB");

  property p_auto_restart;
    @(posedge mclk_in) disable iff (reset_in)
    (segment_error_excess_in && !qam_w && !vsbc_q[`RCR_VSBC_NOAUTO_BIT]) |=> restart_acq_out;
  endproperty
  a_auto_restart: assert property (p_auto_restart) else $error("missed auto restart");

  property p_no_restart;
    @(posedge mclk_in) disable iff (reset_in)
    (vsbc_q[`RCR_VSBC_NOAUTO_BIT] && !soft_req) |=> !restart_acq_out;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("restart while disabled");

  property p_gain;
    @(posedge mclk_in) disable iff (reset_in)
    past_ok_q |-> gain_control_out == ($past(gain_control_raw_in) ^ $past(cfg_q.gain[2]));
  endproperty
  a_gain: assert property (p_gain) else $error("gain polarity mismatch");

  property p_interval;
    @(posedge mclk_in) disable iff (reset_in)
    past_ok_q |-> vsb_interval_count_out[15:0] == {$past(cfg_q.imid), $past(ilow_q)};
  endproperty
  a_interval: assert property (p_interval) else $error("interval bytes misplaced");

  property p_fixed_bits;
    @(posedge mclk_in) disable iff (reset_in)
    ctrl2_q[7:6] == 2'b00 && vsbc_q[3:0] == 4'h2 && gain_q[1:0] == 2'b11;
  endproperty
  a_fixed_bits: assert property (p_fixed_bits) else $error("fixed bit changed");

  c_soft_qam: cover property (@(posedge mclk_in) soft_req && wr_q.data[1]);
  c_read: cover property (@(posedge mclk_in) state_q == rcr_pkg::ST_RD && scl_fall);
  c_restart: cover property (@(posedge mclk_in) restart_d && !soft_req);

endmodule

// file: tb/rcr_host_model.sv
// host processor model on the two-wire host port of the receiver bank
// assumes the bench resolves sda with a pull-up from both open-drain enables
module rcr_host_model (
  input wire logic mclk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_oe_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // eight cycles a phase keeps every phase above the six-cycle minimum
  localparam int HALF = 8;

  initial
  begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  // a repeated start first releases sda while scl is low, so no stop is seen
  task automatic start_cond();
    if (!scl_out)
    begin
      sda_oe_out = 1'b0;
      tick(HALF);
      scl_out = 1'b1;
      tick(HALF);
    end
    sda_oe_out = 1'b1;
    tick(HALF);
    scl_out = 1'b0;
    tick(HALF);
  endtask

  task automatic stop_cond();
    sda_oe_out = 1'b1;
    tick(HALF);
    scl_out = 1'b1;
    tick(HALF);
    sda_oe_out = 1'b0;
    tick(HALF);
  endtask

  // eight data bits and the acknowledge slot; a 1 in tx releases the line
  // sda only moves a full phase after scl falls, so the device never sees a false start
  task automatic xfer9(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      sda_oe_out = ~tx[i];
      tick(HALF);
      scl_out = 1'b1;
      tick(HALF);
      rx[i] = sda_in;
      scl_out = 1'b0;
      tick(HALF);
    end
    sda_oe_out = 1'b0;
  endtask
endmodule

// file: tb/testbench.sv
// self-checking bench for the receiver configuration bank
// assumes the host model on the host port; sda is resolved here with a pull-up
`include "rcr_defines.svh"

module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic scl_in;
  logic sda_in;
  logic host_oe;
  logic sda_drive_out;
  logic sda_oe_out;
  logic segment_error_excess_in = 1'b0;
  logic gain_control_raw_in = 1'b0;
  logic [7:0] vsb_interval_byte2_in = 8'h00;
  logic [1:0] demod_type_select_out;
  logic [1:0] cochannel_filter_ctrl_out;
  logic spectrum_shift_sel_out;
  logic iq_swap_out;
  logic adjacent_filter_bypass_out;
  logic auto_restart_disable_out;
  logic gain_control_out;
  logic [23:0] vsb_interval_count_out;
  logic soft_reset_out;
  logic restart_acq_out;
  int err_count = 0;
  int total_checks = 0;
  int sr_cnt = 0;
  int rs_cnt = 0;
  logic [31:0] lfsr_q = 32'h0000_23e0;
  logic [7:0] cur_low = `RCR_RST_ILOW;
  logic [7:0] offs [5] = '{`RCR_ADDR_CTRL2, `RCR_ADDR_VSBC, `RCR_ADDR_GAIN,
    `RCR_ADDR_ILOW, `RCR_ADDR_IMID};
  logic [7:0] rsts [5] = '{`RCR_RST_CTRL2, `RCR_RST_VSBC, `RCR_RST_GAIN,
    `RCR_RST_ILOW, `RCR_RST_IMID};

  assign sda_in = ~(sda_oe_out | host_oe);

  initial
  begin
    forever #5 mclk_in = ~mclk_in;
  end

  rcr_config_regs dut (
    .mclk_in, .reset_in, .scl_in, .sda_in, .sda_drive_out, .sda_oe_out,
    .segment_error_excess_in, .gain_control_raw_in, .vsb_interval_byte2_in,
    .demod_type_select_out, .spectrum_shift_sel_out, .iq_swap_out,
    .cochannel_filter_ctrl_out, .adjacent_filter_bypass_out, .auto_restart_disable_out,
    .gain_control_out, .vsb_interval_count_out, .soft_reset_out, .restart_acq_out
  );

  rcr_host_model host (
    .mclk_in(mclk_in),
    .sda_in(sda_in),
    .scl_out(scl_in),
    .sda_oe_out(host_oe)
  );

  always @(posedge mclk_in)
  begin
    if (soft_reset_out === 1'b1) sr_cnt++;
    if (restart_acq_out === 1'b1) rs_cnt++;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // demod code 01 counts as VSB, so only the upper bit marks QAM
  function automatic logic exp_iq(input logic [7:0] c2, input logic [1:0] dm);
    return dm[1] & c2[5];
  endfunction

  function automatic logic [1:0] exp_coch(input logic [7:0] c2, input logic [1:0] dm);
    return dm[1] ? 2'b01 : c2[3:2];
  endfunction

  function automatic logic exp_adj(input logic [7:0] c2, input logic [1:0] dm);
    return dm[1] | c2[1];
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  task automatic rnd8(output logic [7:0] v);
    lfsr_q = lfsr_next(lfsr_q);
    v = lfsr_q[7:0];
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic cmp_val(input logic [23:0] got, input logic [23:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      err_count++;
    end
  endtask

  task automatic wr_reg(input logic [7:0] off, input logic [7:0] data);
    logic [8:0] rx;
    host.start_cond();
    host.xfer9({`RCR_I2C_ADDR, 1'b0, 1'b1}, rx);
    cmp_val(24'({rx[0], sda_drive_out}), 24'h00_0000, "address ack");
    host.xfer9({off, 1'b1}, rx);
    host.xfer9({data, 1'b1}, rx);
    host.stop_cond();
  endtask

  task automatic rd_chk(input logic [7:0] off, input logic [7:0] exp);
    logic [8:0] rx;
    host.start_cond();
    host.xfer9({`RCR_I2C_ADDR, 1'b0, 1'b1}, rx);
    host.xfer9({off, 1'b1}, rx);
    host.start_cond();
    host.xfer9({`RCR_I2C_ADDR, 1'b1, 1'b1}, rx);
    host.xfer9(9'h1ff, rx);
    host.stop_cond();
    cmp_val(24'(rx[8:1]), 24'(exp), "readback");
  endtask

  // fresh random raw gain and top byte each time, so stale outputs show up
  task automatic chk_cfg(input logic [7:0] c2, input logic [7:0] gn, input logic [7:0] mid,
    input logic [1:0] dm);
    logic [7:0] r;
    logic [7:0] b;
    rnd8(r);
    rnd8(b);
    gain_control_raw_in = r[0];
    vsb_interval_byte2_in = b;
    tick(2);
    cmp_val(24'(demod_type_select_out), 24'(dm), "demod");
    cmp_val(24'(spectrum_shift_sel_out), 24'(c2[5]), "shift");
    cmp_val(24'(iq_swap_out), 24'(exp_iq(c2, dm)), "iq swap");
    cmp_val(24'(cochannel_filter_ctrl_out), 24'(exp_coch(c2, dm)), "cochannel");
    cmp_val(24'(adjacent_filter_bypass_out), 24'(exp_adj(c2, dm)), "adjacent");
    cmp_val(24'(gain_control_out), 24'(r[0] ^ gn[2]), "gain out");
    cmp_val(vsb_interval_count_out, {b, mid, cur_low}, "interval");
  endtask

  task automatic pulse_excess();
    segment_error_excess_in = 1'b1;
    tick(1);
    segment_error_excess_in = 1'b0;
    tick(4);
  endtask

  initial
  begin
    repeat (90000) @(posedge mclk_in);
    $display("mismatch at %0t: run did not finish in time", $time);
    err_count++;
    give_verdict();
  end

  initial
  begin
    logic [7:0] v;
    logic [7:0] mid;
    logic [7:0] c2;
    logic [7:0] gn;
    logic [1:0] dm;
    int n;
    repeat (8) @(posedge mclk_in);
    #1;
    reset_in = 1'b0;
    tick(4);
    chk_cfg(`RCR_RST_CTRL2, `RCR_RST_GAIN, `RCR_RST_IMID, 2'b00);
    for (int i = 0; i < 5; i++) rd_chk(offs[i], rsts[i]);
    rd_chk(8'h10, 8'h00);
    $display("test reset values done");
    rnd8(mid);
    rnd8(v);
    wr_reg(`RCR_ADDR_CTRL2, 8'h3b);
    wr_reg(`RCR_ADDR_GAIN, 8'hfb);
    wr_reg(`RCR_ADDR_IMID, mid);
    wr_reg(`RCR_ADDR_ILOW, v);
    cur_low = v;
    chk_cfg(`RCR_RST_CTRL2, `RCR_RST_GAIN, `RCR_RST_IMID, 2'b00);
    rd_chk(`RCR_ADDR_CTRL2, 8'h3b);
    rd_chk(`RCR_ADDR_GAIN, 8'h03);
    rd_chk(`RCR_ADDR_IMID, mid);
    n = sr_cnt;
    wr_reg(`RCR_ADDR_CTRL1, 8'h00);
    cmp_val(24'(sr_cnt - n), 24'h00_0001, "soft reset pulses");
    chk_cfg(8'h3b, 8'h03, mid, 2'b00);
    $display("test pending and soft reset done");
    // every demod code; VSB passes see all four co-channel codes
    for (int i = 0; i < 8; i++)
    begin
      rnd8(v);
      dm = i[1:0];
      c2 = {2'b00, v[5], 1'b1, dm ^ {2{i[2]}}, v[1], 1'b1};
      gn = {5'b00000, v[2], 2'b11};
      wr_reg(`RCR_ADDR_CTRL2, c2);
      wr_reg(`RCR_ADDR_GAIN, gn);
      wr_reg(`RCR_ADDR_CTRL1, {6'b001000, dm});
      chk_cfg(c2, gn, mid, dm);
    end
    $display("test modes done");
    wr_reg(`RCR_ADDR_CTRL1, 8'h20);
    wr_reg(`RCR_ADDR_VSBC, 8'h12);
    n = rs_cnt;
    pulse_excess();
    cmp_val(24'(rs_cnt - n), 24'h00_0000, "restart suppressed");
    cmp_val(24'(auto_restart_disable_out), 24'h00_0001, "disable out");
    wr_reg(`RCR_ADDR_VSBC, 8'he2);
    rd_chk(`RCR_ADDR_VSBC, 8'h02);
    n = rs_cnt;
    pulse_excess();
    cmp_val(24'(rs_cnt - n), 24'h00_0001, "auto restart");
    $display("test auto restart done");
    give_verdict();
  end
endmodule
